// ---- rtl/fpu_numeric_exception_unit.sv ----
// Numeric exception unit with AXI4-Lite register access
`timescale 1ns/1ps
// Summary of operation
// - Denormal arithmetic or narrow load raises denormal
// - Denormal flag and mask at bit 1
// - Masked denormal: flag, normalize, continue
// - Unmasked denormal: flag, trap, state unchanged
// - Finite nonzero divided by zero raises it
// - Divide flag and mask at bit 2
// - Masked divide: infinity, xor of signs
// - Log2 and split special masked results
// - Unmasked divide: flag, trap, state unchanged
// - Overflow when rounded result exceeds maximum
// - Integer stores: invalid, never over/underflow
// - Overflow flag and mask at bit 3
// - Masked overflow: rounding-selected default result
// - Unmasked overflow to memory: trap, unchanged
// - Unmasked overflow to register: subtract bias
// - Roundup indicator follows significand rounding direction
// - Scale re-overflow stores signed infinity
// - Tiny nonzero rounded result flags underflow; when masked, only if inexact
// - Underflow flag and mask at bit 4
// - Unmasked underflow to memory: nothing written
// - Unmasked underflow to register: add bias
// - Scale re-underflow stores signed zero
module fpu_numeric_exception_unit
  import fpu_exc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Handler request to the integer core
  output logic             handler_req
);

  // Operand word: sign, 15-bit biased exponent, 16-bit significand.
  // The datapath is a compact model; exponent figures carry the real bias.
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] status;
    logic [15:0] control;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] res;
    logic [31:0] res2;
    logic [1:0]  stack_pointer;
    logic        handler;
    logic        invalid;
  } state_s;

  state_s q, d;

  // Operand field helpers
  function automatic logic is_zero(input logic [31:0] v);
    return v[30:16] == 15'h0000 && v[15:0] == 16'h0000;
  endfunction
  function automatic logic is_denorm(input logic [31:0] v);
    return v[30:16] == 15'h0000 && v[15:0] != 16'h0000;
  endfunction
  function automatic logic is_inf(input logic [31:0] v);
    return v[30:16] == EXP_MAX;
  endfunction
  // Precision control cut: the model truncates, rounding direction comes in the command
  function automatic logic [15:0] prec_cut(input logic [15:0] s, input logic [1:0] pc);
    return (pc == 2'b00) ? {s[15:8], 8'h00} : (pc == 2'b10) ? {s[15:4], 4'h0} : s;
  endfunction

  // Command fields from the write data: op, format, destination, flags
  logic [3:0]  cmd_op;
  logic [1:0]  cmd_fmt;
  logic        cmd_mem;
  logic        cmd_noprec;
  logic [16:0] cmd_exp;
  logic        cmd_rup;
  logic        cmd_inexact;
  logic        cmd_go;
  logic [1:0]  rc;
  logic [14:0] fmt_max;
  logic [14:0] fmt_min;
  logic [16:0] biased;
  logic        ovf;
  logic        unf;
  logic        sgn;
  logic        wr_fire;

  // Next-state logic: bus slave plus exception evaluation
  always_comb begin
    d = q;
    cmd_op = q.w_data[3:0];
    cmd_fmt = q.w_data[5:4];
    cmd_mem = q.w_data[6];
    cmd_noprec = q.w_data[7];
    cmd_rup = q.w_data[8];
    cmd_inexact = q.w_data[9];
    // Unbounded result exponent as signed 17-bit value in the top half
    cmd_exp = {q.w_data[31], q.w_data[31:16]};
    rc = q.control[11:10];
    sgn = q.opa[31] ^ q.opb[31];
    fmt_max = (cmd_fmt == FMT_SINGLE) ? 15'h407e :
              (cmd_fmt == FMT_DOUBLE) ? 15'h43fe : 15'h7ffe;
    fmt_min = (cmd_fmt == FMT_SINGLE) ? 15'h3f81 :
              (cmd_fmt == FMT_DOUBLE) ? 15'h3c01 : 15'h0001;
    ovf = 1'b0;
    unf = 1'b0;
    biased = 17'h00000;
    d.handler = 1'b0;
    d.invalid = 1'b0;
    wr_fire = q.aw_got && q.w_got && !q.bvalid;
    cmd_go = wr_fire && q.aw_addr == CMD_OFS;

    // Address and data taken in either order, response after both
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = 2'b00;
      case (q.aw_addr)
        STATUS_OFS: d.status = q.w_data[15:0];
        CONTROL_OFS: d.control = q.w_data[15:0];
        OPA_OFS: d.opa = q.w_data;
        OPB_OFS: d.opb = q.w_data;
        CMD_OFS: ;
        default: d.bresp = 2'b10;
      endcase
    end

    // Exception evaluation on a command write
    if (cmd_go) begin
      d.res = q.opa;
      d.res2 = q.opb;
      case (cmd_op)
        OP_LOAD: begin
          // Extended loads never report denormal
          if (is_denorm(q.opa) && cmd_fmt != FMT_EXT) begin
            d.status[SUBNORMAL_BIT] = 1'b1;
            if (q.control[SUBNORMAL_BIT]) begin
              d.res = {q.opa[31], 15'h0001, q.opa[15:0]};
              d.stack_pointer = q.stack_pointer - 2'd1;
            end else begin
              d.handler = 1'b1;
            end
          end else begin
            d.stack_pointer = q.stack_pointer - 2'd1;
          end
        end
        OP_DIVIDE, OP_LOG2MUL, OP_EXPSPLIT: begin
          if (is_denorm(q.opa) || is_denorm(q.opb)) begin
            d.status[SUBNORMAL_BIT] = 1'b1;
            if (!q.control[SUBNORMAL_BIT]) begin
              d.handler = 1'b1;
            end
          end
          if (!d.handler && is_zero(q.opb) &&
              !is_zero(q.opa) && !is_inf(q.opa)) begin
            d.status[DIV_NIL_BIT] = 1'b1;
            if (!q.control[DIV_NIL_BIT]) begin
              d.handler = 1'b1;
            end else if (cmd_op == OP_DIVIDE) begin
              d.res = {sgn, EXP_MAX, 16'h8000};
            end else if (cmd_op == OP_LOG2MUL) begin
              d.res = {~q.opa[31], EXP_MAX, 16'h8000};
            end else begin
              d.res2 = {1'b1, EXP_MAX, 16'h8000};
              d.res = {q.opa[31], 31'h00000000};
            end
          end
          if (d.handler) begin
            d.res = q.opa;
            d.res2 = q.opb;
          end
        end
        OP_INTSTORE: begin
          // Range failures are invalid, never overflow or underflow
          d.invalid = cmd_exp[16] == 1'b0 && cmd_exp[15:0] > 16'h403e;
          d.status[0] = q.status[0] | d.invalid;
        end
        default: begin
          // Arithmetic denormal operands are checked before any range test
          if (cmd_op == OP_ARITH && (is_denorm(q.opa) || is_denorm(q.opb))) begin
            d.status[SUBNORMAL_BIT] = 1'b1;
            d.handler = !q.control[SUBNORMAL_BIT];
          end
          // Arithmetic result, store and scaling share range checks; a trap skips them
          ovf = !d.handler && !cmd_exp[16] && cmd_exp[15:0] > {1'b0, fmt_max};
          unf = !d.handler && (cmd_exp[16] || cmd_exp[15:0] < {1'b0, fmt_min})
                && q.opa[15:0] != 16'h0000;
          if (ovf) begin
            d.status[TOO_LARGE_BIT] = 1'b1;
            if (q.control[TOO_LARGE_BIT]) begin
              // Nearest and toward-sign give infinity, else max finite
              if (rc == 2'b00 || (rc == 2'b01 && q.opa[31]) ||
                  (rc == 2'b10 && !q.opa[31])) begin
                d.res = {q.opa[31], EXP_MAX, 16'h8000};
              end else begin
                d.res = {q.opa[31], fmt_max, 16'hffff};
              end
            end else if (cmd_mem) begin
              d.handler = 1'b1;
            end else begin
              biased = cmd_exp - {2'b00, EXP_BIAS};
              // Extended rounding when precision is ignored
              d.res = {q.opa[31], biased[14:0], cmd_noprec ? q.opa[15:0] :
                       prec_cut(q.opa[15:0], q.control[9:8])};
              if (cmd_op == OP_SCALE && !biased[16] && biased[15:0] > 16'h7ffe) begin
                d.res = {q.opa[31], EXP_MAX, 16'h8000};
              end
              d.status[ROUNDUP_BIT] = cmd_rup;
              d.handler = 1'b1;
            end
          end else if (unf) begin
            if (q.control[TINY_BIT]) begin
              d.status[TINY_BIT] = q.status[TINY_BIT] | cmd_inexact;
              d.res = {q.opa[31], 15'h0000, q.opa[15:0] >> 1};
            end else if (cmd_mem) begin
              d.status[TINY_BIT] = 1'b1;
              d.status[ROUNDUP_BIT] = 1'b0;
              d.handler = 1'b1;
            end else begin
              d.status[TINY_BIT] = 1'b1;
              biased = cmd_exp + {2'b00, EXP_BIAS};
              d.res = {q.opa[31], biased[14:0], cmd_noprec ? q.opa[15:0] :
                       prec_cut(q.opa[15:0], q.control[9:8])};
              if (cmd_op == OP_SCALE && (biased[16] || biased[15:0] == 16'h0000)) begin
                d.res = {q.opa[31], 31'h00000000};
              end
              d.status[ROUNDUP_BIT] = cmd_rup;
              d.handler = 1'b1;
            end
          end else if (!d.handler) begin
            d.res = {q.opa[31], cmd_exp[14:0], q.opa[15:0]};
          end
          if (d.handler && cmd_mem) begin
            d.res = q.opa; // Memory image and operands left intact
          end
        end
      endcase
      // Error summary bit is sticky and set by every handler request
      d.status[7] = q.status[7] | d.handler;
    end

    // Read channel, answered one cycle after address
    if (s_axi_rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = 2'b00;
      case (s_axi_araddr)
        STATUS_OFS: d.rdata = {16'h0000, q.status};
        CONTROL_OFS: d.rdata = {16'h0000, q.control};
        OPA_OFS: d.rdata = q.opa;
        OPB_OFS: d.rdata = q.opb;
        RES_OFS: d.rdata = q.res;
        RES2_OFS: d.rdata = q.res2;
        INFO_OFS: d.rdata = {29'h00000000, q.invalid, q.stack_pointer};
        default: begin
          d.rdata = 32'h00000000;
          d.rresp = 2'b10;
        end
      endcase
    end
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.status <= STATUS_RST;
      q.control <= CONTROL_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs from flops; the ready lines are gates or inversions of flop bits
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign handler_req   = q.handler;

  // Unmasked divide by zero traps one cycle after the command
  property p_divzero_trap;
    @(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_op == OP_DIVIDE && is_zero(q.opb) && !is_zero(q.opa) && !is_inf(q.opa)
      && !is_denorm(q.opa) && !q.control[DIV_NIL_BIT]
      |=> handler_req && q.status[DIV_NIL_BIT] && q.res == $past(q.opa);
  endproperty
  a_divzero_trap: assert property (p_divzero_trap) else $error("divide trap missing");

  // Masked divide gives infinity with xor sign
  property p_divzero_masked;
    @(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_op == OP_DIVIDE && is_zero(q.opb) && !is_zero(q.opa) && !is_inf(q.opa)
      && !is_denorm(q.opa) && q.control[DIV_NIL_BIT]
      |=> !handler_req && q.res[30:16] == EXP_MAX && q.res[31] == $past(sgn);
  endproperty
  a_divzero_masked: assert property (p_divzero_masked) else $error("bad masked divide");

  // Extended denormal load never flags
  property p_ext_load;
    @(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_op == OP_LOAD && cmd_fmt == FMT_EXT && !q.status[SUBNORMAL_BIT]
      |=> !q.status[SUBNORMAL_BIT];
  endproperty
  a_ext_load: assert property (p_ext_load) else $error("extended load flagged");

  // Unmasked denormal keeps stack pointer
  property p_denorm_trap;
    @(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_op == OP_LOAD && cmd_fmt == FMT_SINGLE && is_denorm(q.opa)
      && !q.control[SUBNORMAL_BIT]
      |=> handler_req && $stable(q.stack_pointer) && q.status[SUBNORMAL_BIT];
  endproperty
  a_denorm_trap: assert property (p_denorm_trap) else $error("denormal trap wrong");

  // Integer store never sets overflow or underflow
  property p_int_store;
    @(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_op == OP_INTSTORE
      |=> $stable(q.status[TINY_BIT:TOO_LARGE_BIT]) && !handler_req;
  endproperty
  a_int_store: assert property (p_int_store) else $error("integer store over/underflow");

  // Handler request is a single-cycle pulse
  property p_pulse;
    @(posedge aclk) disable iff (!aresetn)
    handler_req |=> !handler_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("handler request too long");

  // Unmasked overflow to register subtracts the bias
  property p_ovf_bias;
    @(posedge aclk) disable iff (!aresetn)
    cmd_go && ovf && !cmd_mem && !q.control[TOO_LARGE_BIT] && cmd_op != OP_SCALE
      |=> handler_req && q.status[TOO_LARGE_BIT]
          && q.res[30:16] == $past(cmd_exp[14:0]) - EXP_BIAS;
  endproperty
  a_ovf_bias: assert property (p_ovf_bias) else $error("overflow bias");

  // Unmasked memory underflow leaves result image unchanged
  property p_unf_mem;
    @(posedge aclk) disable iff (!aresetn)
    cmd_go && cmd_op == OP_STORE && cmd_mem && unf && !ovf && !q.control[TINY_BIT]
      |=> handler_req && q.res == $past(q.opa) && !q.status[ROUNDUP_BIT];
  endproperty
  a_unf_mem: assert property (p_unf_mem) else $error("memory underflow wrote");

endmodule

// ---- rtl/fpu_exc_pkg.sv ----
// Constants and types for the numeric exception unit
package fpu_exc_pkg;
  // Status and control word bit positions
  localparam int SUBNORMAL_BIT = 1;
  localparam int DIV_NIL_BIT   = 2;
  localparam int TOO_LARGE_BIT = 3;
  localparam int TINY_BIT      = 4;
  localparam int INEXACT_BIT   = 5;
  localparam int ROUNDUP_BIT   = 9;
  // Exponent bias applied on unmasked overflow or underflow
  localparam logic [14:0] EXP_BIAS = 15'h6000;
  localparam logic [14:0] EXP_MAX  = 15'h7fff;
  // Register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CONTROL_OFS = 8'h04;
  localparam logic [7:0] OPA_OFS    = 8'h08;
  localparam logic [7:0] OPB_OFS    = 8'h0c;
  localparam logic [7:0] CMD_OFS    = 8'h10;
  localparam logic [7:0] RES_OFS    = 8'h14;
  localparam logic [7:0] RES2_OFS   = 8'h18;
  localparam logic [7:0] INFO_OFS   = 8'h1c;
  // Reset values
  localparam logic [15:0] STATUS_RST  = 16'h0000;
  localparam logic [15:0] CONTROL_RST = 16'h037f;
  // Operation codes
  localparam logic [3:0] OP_LOAD     = 4'h0;
  localparam logic [3:0] OP_ARITH    = 4'h1;
  localparam logic [3:0] OP_DIVIDE   = 4'h2;
  localparam logic [3:0] OP_LOG2MUL  = 4'h3;
  localparam logic [3:0] OP_EXPSPLIT = 4'h4;
  localparam logic [3:0] OP_STORE    = 4'h5;
  localparam logic [3:0] OP_SCALE    = 4'h6;
  localparam logic [3:0] OP_INTSTORE = 4'h7;
  // Operand formats
  localparam logic [1:0] FMT_SINGLE = 2'h0;
  localparam logic [1:0] FMT_DOUBLE = 2'h1;
  localparam logic [1:0] FMT_EXT    = 2'h2;
endpackage

// ---- bench/fpu_handler_model.sv ----
// Model of the integer core that counts handler invocations
`timescale 1ns/1ps
module fpu_handler_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Request from the exception unit
  input  wire logic        handler_req,
  // Invocations seen so far
  output logic      [15:0] count_q
);
  // Each high cycle is one invocation; a stuck request overcounts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 16'h0000;
    end else if (handler_req) begin
      count_q <= count_q + 16'h0001;
    end
  end
endmodule

// ---- bench/fpu_numeric_exception_unit_tb_top.sv ----
// Self-checking bench for the numeric exception unit
`timescale 1ns/1ps
module fpu_numeric_exception_unit_tb_top
  import fpu_exc_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, handler_req;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st, rs, r2;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] hcnt, hd;
  int fails, checked;
  int cyc = 0;

  fpu_numeric_exception_unit dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .handler_req(handler_req));
  fpu_handler_model core_u (.aclk(aclk), .aresetn(aresetn), .handler_req(handler_req),
    .count_q(hcnt));

  // Clock at 40 MHz
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Cycle ceiling far above the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    checked = checked + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
      b = bvalid;
    end
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ok;
    ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    while (!ok) begin
      @(posedge aclk);
      ok = rvalid;
    end
    d = rdata;
    rready <= 1'b0;
  endtask

  // One command with fresh status; status, results and invocation delta come back
  task automatic run(input logic [15:0] ctl, input logic [31:0] a, b, cmd);
    logic [15:0] h0;
    wr(CONTROL_OFS, {16'h0000, ctl});
    wr(STATUS_OFS, 32'h0000_0000);
    wr(OPA_OFS, a);
    wr(OPB_OFS, b);
    h0 = hcnt;
    wr(CMD_OFS, cmd);
    repeat (3) @(posedge aclk);
    hd = hcnt - h0;
    rd(STATUS_OFS, st);
    rd(RES_OFS, rs);
    rd(RES2_OFS, r2);
  endtask

  task automatic t_reset();
    rd(STATUS_OFS, st);
    chk("status reset", {16'h0000, STATUS_RST}, st);
    rd(CONTROL_OFS, st);
    chk("control reset", {16'h0000, CONTROL_RST}, st);
    rd(8'h20, st);
    chk("unmapped read", 32'h0000_0000, st);
    chk("unmapped rresp", 32'h2, {30'h0, rresp});
    wr(8'h24, 32'h0000_0001);
    chk("unmapped bresp", 32'h2, {30'h0, bresp});
  endtask

  task automatic t_denormal();
    logic [31:0] i0, i1;
    run(16'h037f, 32'h0000_0001, 32'h3fff_8000, 32'h3fff_0000);
    chk("single load flag", 32'h2, st & 32'h2);
    chk("masked no handler", 32'h0, {16'h0, hd});
    chk("normalized load", 32'h0001_0001, rs);
    run(16'h037f, 32'h0000_0001, 32'h3fff_8000, 32'h3fff_0020);
    chk("ext load flag", 32'h0, st & 32'h2);
    run(16'h037f, 32'h3fff_8000, 32'h0000_0001, 32'h3fff_0001);
    chk("arith denormal flag", 32'h2, st & 32'h2);
    chk("arith no handler", 32'h0, {16'h0, hd});
    rd(INFO_OFS, i0);
    run(16'h037d, 32'h0000_0001, 32'h3fff_8000, 32'h3fff_0000);
    rd(INFO_OFS, i1);
    chk("unmasked flag", 32'h2, st & 32'h2);
    chk("unmasked handler", 32'h1, {16'h0, hd});
    chk("unmasked result", 32'h0000_0001, rs);
    chk("stack pointer", i0 & 32'h3, i1 & 32'h3);
    run(16'h037d, 32'h3fff_8000, 32'h0000_0001, 32'h3fff_0001);
    chk("arith trap", 32'h1, {16'h0, hd});
  endtask

  task automatic t_divide();
    run(16'h037f, 32'h3fff_8000, 32'h8000_0000, 32'h3fff_0002);
    chk("divide flag", 32'h4, st & 32'h4);
    chk("divide inf", 32'hffff, rs >> 16);
    run(16'h037f, 32'h3fff_8000, 32'h0000_0000, 32'h3fff_0003);
    chk("log2 flag", 32'h4, st & 32'h4);
    chk("log2 sign", 32'h1, rs >> 31);
    run(16'h037f, 32'hbfff_8000, 32'h0000_0000, 32'h0000_0004);
    chk("split slot0", 32'h8000_0000, rs);
    chk("split slot1", 32'hffff, r2 >> 16);
    run(16'h037b, 32'h3fff_8000, 32'h0000_0000, 32'h3fff_0002);
    chk("unmasked divide", 32'h4, st & 32'h4);
    chk("divide handler", 32'h1, {16'h0, hd});
    chk("divide unchanged", 32'h3fff_8000, rs);
  endtask

  task automatic t_overflow();
    run(16'h037f, 32'h3fff_8000, 32'h3fff_8000, 32'h7fff_0001);
    chk("masked ovf flag", 32'h8, st & 32'h8);
    chk("nearest default", 32'h7fff, (rs >> 16) & 32'h7fff);
    run(16'h0f7f, 32'h3fff_8000, 32'h3fff_8000, 32'h7fff_0021);
    chk("chop default", 32'h7ffe, (rs >> 16) & 32'h7fff);
    run(16'h0377, 32'h3fff_8000, 32'h3fff_8000, 32'h7fff_0101);
    chk("biased ovf", 32'h1fff, (rs >> 16) & 32'h7fff);
    chk("roundup set", 32'h208, st & 32'h208);
    chk("ovf handler", 32'h1, {16'h0, hd});
    run(16'h0077, 32'h3fff_80ff, 32'h3fff_8000, 32'h7fff_0001);
    chk("precision cut", 32'h8000, rs & 32'hffff);
    run(16'h0077, 32'h3fff_80ff, 32'h3fff_8000, 32'h7fff_0081);
    chk("extended round", 32'h80ff, rs & 32'hffff);
    run(16'h0377, 32'h3fff_8000, 32'h3fff_8000, 32'h7fff_0055);
    chk("mem ovf flag", 32'h8, st & 32'h8);
    chk("mem ovf handler", 32'h1, {16'h0, hd});
    chk("mem ovf result", 32'h3fff_8000, rs);
    run(16'h037f, 32'h3fff_8000, 32'h3fff_8000, 32'h7fff_0047);
    chk("int store", 32'h1, st & 32'h19);
  endtask

  task automatic t_underflow();
    run(16'h036f, 32'h3fff_8000, 32'h3fff_8000, 32'hfff6_0201);
    chk("biased unf", 32'h5ff6, (rs >> 16) & 32'h7fff);
    chk("unf flag", 32'h10, st & 32'h210);
    chk("unf handler", 32'h1, {16'h0, hd});
    run(16'h036f, 32'h3fff_8000, 32'h3fff_8000, 32'hfff6_0255);
    chk("mem unf result", 32'h3fff_8000, rs);
    chk("mem unf handler", 32'h1, {16'h0, hd});
    run(16'h036f, 32'hbfff_8000, 32'h3fff_8000, 32'h9000_0006);
    chk("scale zero", 32'h8000_0000, rs);
    run(16'h037f, 32'h3fff_8000, 32'h3fff_8000, 32'hfff6_0001);
    chk("exact masked unf", 32'h0, st & 32'h10);
    run(16'h037f, 32'h3fff_8000, 32'h3fff_8000, 32'hfff6_0201);
    chk("inexact masked unf", 32'h10, st & 32'h10);
    chk("masked no handler", 32'h0, {16'h0, hd});
  endtask

  // Main sequence: reset for 20 cycles, then each scenario in turn
  initial begin
    fails = 0;
    checked = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_denormal();
    t_divide();
    t_overflow();
    t_underflow();
    results();
  end
endmodule
